//--- design/tcpd_regs.vh
/*
 Constants for the Type-C role, orientation and debug detection block.
 Assumes a single 250 MHz clock domain and plain-port configuration.
*/
`ifndef TCPD_REGS_VH
`define TCPD_REGS_VH

// Three-level strap codes after the pin front end.
`define TCPD_STRAP_LOW   2'h0
`define TCPD_STRAP_FLOAT 2'h1
`define TCPD_STRAP_HIGH  2'h2

// Port role codes.
`define TCPD_ROLE_SINK   2'h0
`define TCPD_ROLE_DRP    2'h1
`define TCPD_ROLE_SOURCE 2'h2

// Orientation codes.
`define TCPD_FLIP_NONE 2'h0
`define TCPD_FLIP_CC1  2'h1
`define TCPD_FLIP_CC2  2'h2

// Two-wire slave addresses and the strap bit position within them.
`define TCPD_ADDR_HIGH  7'h62
`define TCPD_ADDR_LOW   7'h42
`define TCPD_ADDR_BIT   5

// Interrupt bit positions in the sticky status vector.
`define TCPD_IRQ_FDONE  0
`define TCPD_IRQ_FFAIL  1
`define TCPD_IRQ_LOOP   2
`define TCPD_IRQ_LBATT  3
`define TCPD_IRQ_AUDIO  4
`define TCPD_IRQ_W      5

// Cycles a forced role change may take before it counts as failed.
`define TCPD_FORCE_TO   8'hFF
// Attach/detach flips within the loop window that count as a loop.
`define TCPD_LOOP_MAX   4'h8
// Edges after reset release before the power-up strap sample, which is taken on the next edge.
`define TCPD_BOOT_WAIT  2'h2

// Reset values.
`define TCPD_IRQ_RST    5'h00
`define TCPD_MASK_RST   1'b1

`endif

//--- design/tcpd_detect.v
/*
 Role, orientation and debug detection logic of a Type-C port controller.
 Assumes the analog front end reports strap levels and CC terminations as
 levels from outside this clock domain; they are synchronised here.
*/
`timescale 1ns/1ps
`include "tcpd_regs.vh"
// Notes on behaviour
// - Role strap sampled on enable fall, power-up or soft reset.
// - Address strap sampled likewise; high 62h, float pin-only, low 42h.
// - After sampling, debug output driven low when debug system seen.
// - After sampling, orientation output low for CC1, high for CC2.
// - Role output pulled low when source, released when sink.
// - Orientation code 00 open, 10 only CC2, 01 only CC1.
// - Debug system on both lines takes decoded orientation code.
// - Unpowered pull-down on CC is analog, outside this logic.
// - Sink sees Rp on both lines: debug system, role released.
// - Source sees Rd on both lines: debug system, role low.
// - Dual-role resolves a role then behaves as that role.
// - Host mode reports debug; configured role overrides strap.
// - Pin-only mode pulls audio output low on audio accessory.
// - Host mode reports audio only when audio detection enabled.
// - Forced role attempted; failure restores role; done or failed flag.
// - Loop fix enabled and attach loops: recover and flag.
// - Low-battery sink: attach as sink to dual-role, detach from sink.
// - Low-battery threshold programmable; flag on each invocation.
// - Status bits hold until a one is written to them.
// - Global mask set at reset; pending event shows once cleared.
// - Slave address bit 5 carries the sampled address strap.
module tcpd_detect (
  // Clock and reset
  input  wire       clk,
  input  wire       rst_n,
  // Pins and analog front end (asynchronous)
  input  wire       en_n_pin,
  input  wire [1:0] role_strap_lvl,
  input  wire [1:0] addr_strap_lvl,
  input  wire       cc1_term,
  input  wire       cc2_term,
  input  wire       audio_seen,
  input  wire       partner_drp,
  input  wire       partner_sink,
  input  wire       attached,
  input  wire [1:0] resolved_role,
  input  wire [3:0] batt_level,
  // Processor-side configuration
  input  wire       soft_reset_cmd,
  input  wire       cfg_role_valid,
  input  wire [1:0] cfg_role,
  input  wire       cfg_audio_en,
  input  wire       forced_sink_req,
  input  wire       forced_source_req,
  input  wire       loop_fix_enable,
  input  wire       cable_fix_enable,
  input  wire       low_batt_sink_enable,
  input  wire [3:0] low_batt_threshold,
  input  wire       irq_mask_set,
  input  wire       irq_mask_clr,
  input  wire [4:0] irq_clr,
  // Pins driven
  output wire       debug_strap_out,
  output wire       debug_strap_oe,
  output wire       addr_strap_flip_out,
  output wire       addr_strap_flip_oe,
  output wire       attach_role_out,
  output wire       attach_role_oe,
  output wire       irq_audio_out,
  output wire       irq_audio_oe,
  // Status
  output reg  [1:0] plug_flip_code,
  output reg        debug_seen,
  output reg        audio_report,
  output reg  [1:0] strap_role,
  output reg        host_mode,
  output reg  [6:0] slave_addr,
  output reg  [1:0] active_role,
  output reg        sink_detach,
  output reg  [4:0] irq_status,
  output reg        irq_mask
);

  // Two-stage synchronisers for every asynchronous input.
  localparam SW = 17;
  // Vector layout, top down: enable, straps, terminations, partner view, battery.
  wire [SW-1:0] async_in = {en_n_pin, role_strap_lvl, addr_strap_lvl, cc1_term, cc2_term,
                            audio_seen, partner_drp, partner_sink, attached,
                            resolved_role, batt_level};
  reg  [SW-1:0] sync1_reg;
  reg  [SW-1:0] sync2_reg;
  // No reset here, so real pin levels are already waiting when reset lifts.
  always @(posedge clk) begin
    sync1_reg <= async_in;
    sync2_reg <= sync1_reg;
  end
  // Only the second flop is read, never the possibly metastable first one.
  wire       en_n_s   = sync2_reg[16];
  wire [1:0] rstrap_s = sync2_reg[15:14];
  wire [1:0] astrap_s = sync2_reg[13:12];
  wire       cc1_s    = sync2_reg[11];
  wire       cc2_s    = sync2_reg[10];
  wire       audio_s  = sync2_reg[9];
  wire       pdrp_s   = sync2_reg[8];
  wire       psnk_s   = sync2_reg[7];
  wire       att_s    = sync2_reg[6];
  wire [1:0] rrole_s  = sync2_reg[5:4];
  wire [3:0] batt_s   = sync2_reg[3:0];

  // Strap decode shared by role selection.
  function [1:0] strap_to_role;
    input [1:0] lvl;
    begin
      if (lvl == `TCPD_STRAP_HIGH)
        strap_to_role = `TCPD_ROLE_SOURCE;
      else if (lvl == `TCPD_STRAP_LOW)
        strap_to_role = `TCPD_ROLE_SINK;
      else
        strap_to_role = `TCPD_ROLE_DRP;
    end
  endfunction

  // Power-up sampling waits until the synchronisers hold real pin levels.
  reg [1:0] boot_reg;
  reg       en_n_d_reg;
  reg       sampled_reg;
  wire      boot_sample = (boot_reg == `TCPD_BOOT_WAIT) && !en_n_s;
  wire      en_fall     = en_n_d_reg && !en_n_s;
  wire      sample_now  = en_fall || boot_sample || soft_reset_cmd;

  always @(posedge clk) begin
    if (!rst_n) begin
      boot_reg    <= 2'h0;
      en_n_d_reg  <= 1'b1;
      sampled_reg <= 1'b0;
      strap_role  <= `TCPD_ROLE_DRP;
      host_mode   <= 1'b0;
      slave_addr  <= `TCPD_ADDR_LOW;
    end else begin
      en_n_d_reg <= en_n_s;
      if (boot_reg != 2'h3)
        boot_reg <= boot_reg + 2'h1;
      if (sample_now) begin
        sampled_reg <= 1'b1;
        strap_role  <= strap_to_role(rstrap_s);
        host_mode   <= (astrap_s != `TCPD_STRAP_FLOAT);
        slave_addr  <= (astrap_s == `TCPD_STRAP_HIGH) ? `TCPD_ADDR_HIGH : `TCPD_ADDR_LOW;
      end
    end
  end

  // configured role overrides strap in host mode
  wire [1:0] cfg_eff = (host_mode && cfg_role_valid) ? cfg_role : strap_role;

  // Role arbitration: force requests, low-battery sink, loop recovery.
  localparam ST_IDLE  = 3'h1;
  localparam ST_FORCE = 3'h2;
  localparam ST_FIX   = 3'h4;
  reg [2:0] state_reg;
  reg [1:0] prev_role_reg;
  reg [1:0] want_role_reg;
  reg [7:0] tmo_reg;
  reg [3:0] flip_cnt_reg;
  reg       att_d_reg;
  reg       lbatt_d_reg;
  reg [4:0] ev;
  // The battery level is synchronised; the threshold is already on this clock.
  wire      low_batt   = low_batt_sink_enable && (batt_s < low_batt_threshold);
  wire      lbatt_fire = low_batt && !lbatt_d_reg;
  wire      att_edge   = att_s != att_d_reg;

  always @(posedge clk) begin
    if (!rst_n) begin
      state_reg     <= ST_IDLE;
      active_role   <= `TCPD_ROLE_DRP;
      prev_role_reg <= `TCPD_ROLE_DRP;
      want_role_reg <= `TCPD_ROLE_SINK;
      tmo_reg       <= 8'h00;
      flip_cnt_reg  <= 4'h0;
      att_d_reg     <= 1'b0;
      lbatt_d_reg   <= 1'b0;
      sink_detach   <= 1'b0;
      ev            <= 5'h00;
    end else begin
      // Event strobes last one cycle; the sticky status below keeps them.
      ev          <= 5'h00;
      att_d_reg   <= att_s;
      lbatt_d_reg <= low_batt;
      sink_detach <= low_batt && psnk_s;
      // Attach flips saturate so that a long burst cannot wrap back to calm.
      if (att_edge && flip_cnt_reg != 4'hF)
        flip_cnt_reg <= flip_cnt_reg + 4'h1;
      case (state_reg)
        ST_IDLE: begin
          if (forced_sink_req || forced_source_req) begin
            prev_role_reg <= active_role;
            want_role_reg <= forced_sink_req ? `TCPD_ROLE_SINK : `TCPD_ROLE_SOURCE;
            active_role   <= forced_sink_req ? `TCPD_ROLE_SINK : `TCPD_ROLE_SOURCE;
            tmo_reg       <= `TCPD_FORCE_TO;
            state_reg     <= ST_FORCE;
          end else if ((loop_fix_enable || cable_fix_enable) &&
                       flip_cnt_reg >= `TCPD_LOOP_MAX) begin
            ev[`TCPD_IRQ_LOOP] <= 1'b1;
            active_role  <= (active_role == `TCPD_ROLE_SINK) ? `TCPD_ROLE_SOURCE
                                                             : `TCPD_ROLE_SINK;
            flip_cnt_reg <= 4'h0;
            state_reg    <= ST_FIX;
          end else if (low_batt && pdrp_s) begin
            active_role <= `TCPD_ROLE_SINK;
            if (lbatt_fire)
              ev[`TCPD_IRQ_LBATT] <= 1'b1;
          end else if (lbatt_fire) begin
            ev[`TCPD_IRQ_LBATT] <= 1'b1;
          end else if (cfg_eff == `TCPD_ROLE_DRP) begin
            active_role <= rrole_s;
          end else begin
            active_role <= cfg_eff;
          end
          // A quiet detach ends any loop that was building up.
          if (!att_s && !att_edge)
            flip_cnt_reg <= 4'h0;
        end
        ST_FORCE: begin
          if (att_s && rrole_s == want_role_reg) begin
            ev[`TCPD_IRQ_FDONE] <= 1'b1;
            state_reg <= ST_IDLE;
          end else if (tmo_reg == 8'h00) begin
            ev[`TCPD_IRQ_FFAIL] <= 1'b1;
            active_role <= prev_role_reg;
            state_reg   <= ST_IDLE;
          end else begin
            tmo_reg <= tmo_reg - 8'h01;
          end
        end
        ST_FIX: begin
          if (att_s)
            state_reg <= ST_IDLE;
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  wire is_src = (active_role == `TCPD_ROLE_SOURCE);
  always @(posedge clk) begin
    if (!rst_n) begin
      plug_flip_code <= `TCPD_FLIP_NONE;
      debug_seen     <= 1'b0;
      audio_report   <= 1'b0;
    end else begin
      // Both lines terminated means a debug test system is attached.
      debug_seen <= cc1_s && cc2_s;
      if (cc1_s && !cc2_s)
        plug_flip_code <= `TCPD_FLIP_CC1;
      else if (cc2_s && !cc1_s)
        plug_flip_code <= `TCPD_FLIP_CC2;
      else if (!cc1_s && !cc2_s)
        plug_flip_code <= `TCPD_FLIP_NONE;
      else if (plug_flip_code == `TCPD_FLIP_NONE)
        plug_flip_code <= `TCPD_FLIP_CC1;
      audio_report <= host_mode && cfg_audio_en && audio_s;
    end
  end

  // sticky status with set winning over clear
  // The audio interrupt fires on the rising edge of the report, not its level.
  reg        audio_d_reg;
  wire [4:0] ev_all = {ev[4] | (audio_report & ~audio_d_reg), ev[3:0]};
  always @(posedge clk) begin
    if (!rst_n) begin
      irq_status  <= `TCPD_IRQ_RST;
      irq_mask    <= `TCPD_MASK_RST;
      audio_d_reg <= 1'b0;
    end else begin
      audio_d_reg <= audio_report;
      irq_status  <= (irq_status & ~irq_clr) | ev_all;
      // Mask set wins over a clear in the same cycle, the safe way round.
      if (irq_mask_set)
        irq_mask <= 1'b1;
      else if (irq_mask_clr)
        irq_mask <= 1'b0;
    end
  end

  // debug output, low means debug system seen
  assign debug_strap_out = ~debug_seen;
  assign debug_strap_oe  = sampled_reg;
  assign addr_strap_flip_out = (plug_flip_code == `TCPD_FLIP_CC2);
  assign addr_strap_flip_oe  = sampled_reg;
  // role output driven low only as source
  assign attach_role_out = 1'b0;
  assign attach_role_oe  = att_d_reg && is_src;
  assign irq_audio_out = 1'b0;
  assign irq_audio_oe  = host_mode ? (!irq_mask && (irq_status != 5'h00))
                                   : (sampled_reg && audio_s);

endmodule

//--- verif/tcpd_checker.sv
/*
 Port checker for the role, orientation and debug detection block.
 Assumes it is bound to every instance of tcpd_detect, one clock domain.
*/
`timescale 1ns/1ps
module tcpd_checker (
  // Clock, reset and causes
  input wire       clk,
  input wire       rst_n,
  input wire       en_n_pin,
  input wire       soft_reset_cmd,
  input wire       forced_sink_req,
  input wire       forced_source_req,
  input wire [4:0] irq_clr,
  // Observed outputs
  input wire       debug_strap_out,
  input wire       debug_strap_oe,
  input wire       addr_strap_flip_out,
  input wire       addr_strap_flip_oe,
  input wire       attach_role_out,
  input wire       attach_role_oe,
  input wire       irq_audio_oe,
  input wire [1:0] plug_flip_code,
  input wire       debug_seen,
  input wire [1:0] strap_role,
  input wire       host_mode,
  input wire [6:0] slave_addr,
  input wire [4:0] irq_status,
  input wire       irq_mask
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  reg [3:0] quiet_reg;
  // Calm cycles since the last sampling cause; a resample lands a few edges late.
  always @(posedge clk) begin
    if (!rst_n || en_n_pin || soft_reset_cmd) quiet_reg <= 4'h0;
    else if (quiet_reg != 4'hF) quiet_reg <= quiet_reg + 4'h1;
  end
  sequence force_ask;
    (forced_sink_req || forced_source_req) && irq_status[1:0] == 2'h0;
  endsequence
  sequence force_end;
    ##[1:300] (irq_status[0] || irq_status[1]);
  endsequence
  chk_flip_pin_code: assert property (addr_strap_flip_oe && $stable(plug_flip_code)
    |-> addr_strap_flip_out == (plug_flip_code == 2'h2)) else $error("flip pin wrong");
  chk_debug_pin_low: assert property (debug_strap_oe && $stable(debug_seen)
    |-> debug_strap_out == !debug_seen) else $error("debug pin wrong");
  chk_role_drive_low: assert property (attach_role_oe |-> !attach_role_out)
    else $error("role pin driven high");
  chk_addr_fixed_bits: assert property ({slave_addr[6], slave_addr[4:0]} == 6'h22)
    else $error("slave address fixed bits wrong");
  chk_mask_keeps_quiet: assert property (irq_mask && $past(irq_mask) && host_mode
    |-> !irq_audio_oe) else $error("irq driven while masked");
  chk_reset_state: assert property ($rose(rst_n) |-> irq_mask && irq_status == 5'h00
    && !addr_strap_flip_oe) else $error("reset state wrong");
  chk_irq_sticky: assert property (1'b1 |=>
    (($past(irq_status) & ~$past(irq_clr)) & ~irq_status) == 5'h00) else $error("irq lost");
  chk_strap_hold: assert property (quiet_reg == 4'hF |-> $stable(strap_role)
    && $stable(slave_addr) && $stable(host_mode)) else $error("strap changed");
  chk_force_outcome: assert property (force_ask |-> force_end)
    else $error("force gave no outcome");
endmodule
bind tcpd_detect tcpd_checker tcpd_checker_i (.clk(clk), .rst_n(rst_n), .en_n_pin(en_n_pin),
  .soft_reset_cmd(soft_reset_cmd), .forced_sink_req(forced_sink_req),
  .forced_source_req(forced_source_req), .irq_clr(irq_clr), .debug_strap_out(debug_strap_out),
  .debug_strap_oe(debug_strap_oe), .addr_strap_flip_out(addr_strap_flip_out),
  .addr_strap_flip_oe(addr_strap_flip_oe), .attach_role_out(attach_role_out),
  .attach_role_oe(attach_role_oe), .irq_audio_oe(irq_audio_oe),
  .plug_flip_code(plug_flip_code), .debug_seen(debug_seen), .strap_role(strap_role),
  .host_mode(host_mode), .slave_addr(slave_addr), .irq_status(irq_status), .irq_mask(irq_mask));

//--- verif/tcpd_partner.sv
/*
 Link partner model seen through the CC front end.
 Assumes the bench picks what is plugged; every line reads open while unplugged.
*/
`timescale 1ns/1ps
module tcpd_partner (
  // Clock and bench choice
  input  wire       clk,
  input  wire [2:0] plug_sel,
  input  wire [1:0] as_role,
  // Front-end view of the partner
  output reg        cc1_term,
  output reg        cc2_term,
  output reg        attached,
  output reg  [1:0] resolved_role,
  output reg        partner_drp,
  output reg        partner_sink,
  output reg        audio_seen
);
  always @(posedge clk) begin
    cc1_term      <= plug_sel == 3'h1 || plug_sel == 3'h3;
    cc2_term      <= plug_sel == 3'h2 || plug_sel == 3'h3;
    attached      <= plug_sel != 3'h0;
    resolved_role <= as_role;
    partner_drp   <= plug_sel == 3'h5;
    partner_sink  <= plug_sel == 3'h6;
    audio_seen    <= plug_sel == 3'h4;
  end
endmodule

//--- verif/tcpd_detect_tb.sv
/*
 Self-checking bench for the detection block.
 Assumes the checker binds itself and the partner model drives the CC view.
*/
`timescale 1ns/1ps
`include "tcpd_regs.vh"
module tcpd_detect_tb;
  logic clk, rst_n, en_n_pin, srst, fsnk, fsrc, mset, mclr, cfgv, aud;
  logic [1:0] rs, as, cfgr, asr;
  logic [2:0] ps;
  logic [4:0] clr;
  logic lbe, lfe, cfe;
  logic [3:0] lbth;
  // Plug choices and the orientation code each must leave behind.
  logic [2:0] ps_tab [6] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h0, 3'h3};
  logic [1:0] pfc_tab [6] = '{2'h0, 2'h1, 2'h2, 2'h2, 2'h0, 2'h1};
  logic cc1, cc2, att, pdrp, psnk, aseen;
  logic [1:0] rr;
  wire dso, dsoe, afo, afoe, aro, aroe, iao, iaoe, dbg, arep, hm, sd, msk;
  wire [1:0] pfc, sr, acr;
  wire [6:0] sa;
  wire [4:0] ist;
  int n_fail, n_checks;
  tcpd_partner tcpd_partner_i (.clk(clk), .plug_sel(ps), .as_role(asr), .cc1_term(cc1),
    .cc2_term(cc2), .attached(att), .resolved_role(rr), .partner_drp(pdrp),
    .partner_sink(psnk), .audio_seen(aseen));
  tcpd_detect tcpd_detect_i (.clk(clk), .rst_n(rst_n), .en_n_pin(en_n_pin),
    .role_strap_lvl(rs), .addr_strap_lvl(as), .cc1_term(cc1), .cc2_term(cc2),
    .audio_seen(aseen), .partner_drp(pdrp), .partner_sink(psnk), .attached(att),
    .resolved_role(rr), .batt_level(4'h8), .soft_reset_cmd(srst), .cfg_role_valid(cfgv),
    .cfg_role(cfgr), .cfg_audio_en(aud), .forced_sink_req(fsnk), .forced_source_req(fsrc),
    .loop_fix_enable(lfe), .cable_fix_enable(cfe), .low_batt_sink_enable(lbe),
    .low_batt_threshold(lbth), .irq_mask_set(mset), .irq_mask_clr(mclr), .irq_clr(clr),
    .debug_strap_out(dso), .debug_strap_oe(dsoe), .addr_strap_flip_out(afo),
    .addr_strap_flip_oe(afoe), .attach_role_out(aro), .attach_role_oe(aroe),
    .irq_audio_out(iao), .irq_audio_oe(iaoe), .plug_flip_code(pfc), .debug_seen(dbg),
    .audio_report(arep), .strap_role(sr), .host_mode(hm), .slave_addr(sa),
    .active_role(acr), .sink_detach(sd), .irq_status(ist), .irq_mask(msk));
  // Free-running 4 ns clock.
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic chk(input string nm, input logic [6:0] e, input logic [6:0] g);
    n_checks++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s: expected %h, seen %h", nm, e, g);
    end
  endtask
  // Bounded wait for one status bit; running out counts as a mismatch.
  task automatic wait_irq(input int b, input int lim);
    int k;
    for (k = 0; k < lim && ist[b] !== 1'b1; k++) cyc(1);
    chk("irq bit", 7'h01, {6'h00, ist[b]});
  endtask
  // Rapid plug and unplug that makes attach resolution look like a loop.
  task automatic loop_burst;
    int k;
    for (k = 0; k < 12; k++) begin
      ps <= k[0] ? 3'h0 : 3'h1;
      cyc(1);
    end
    ps <= 3'h1;
  endtask
  task automatic summarize;
    $display("checks %0d, mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  initial begin
    {rst_n, srst, fsnk, fsrc, mset, mclr, cfgv, aud, cfgr, clr, ps, asr} = '0;
    {lbe, lfe, cfe, lbth} = '0;
    en_n_pin = 1'b0;
    rs = `TCPD_STRAP_HIGH;
    as = `TCPD_STRAP_LOW;
    cyc(10);
    rst_n <= 1'b1;
    cyc(1);
    chk("mask", 7'h01, {6'h00, msk});
    cyc(8);
    chk("role", `TCPD_ROLE_SOURCE, {5'h00, sr});
    chk("addr", `TCPD_ADDR_LOW, sa);
    chk("host", 7'h01, {6'h00, hm});
    chk("debug oe", 7'h01, {6'h00, dsoe});
    chk("flip oe", 7'h01, {6'h00, afoe});
    rs <= `TCPD_STRAP_LOW;
    as <= `TCPD_STRAP_HIGH;
    cyc(8);
    chk("held", `TCPD_ADDR_LOW, sa);
    srst <= 1'b1;
    cyc(1);
    srst <= 1'b0;
    cyc(8);
    chk("addr", `TCPD_ADDR_HIGH, sa);
    chk("role", `TCPD_ROLE_SINK, {5'h00, sr});
    $display("test straps done");
    foreach (pfc_tab[i]) begin
      ps <= ps_tab[i];
      cyc(8);
      chk("code", {5'h00, pfc_tab[i]}, {5'h00, pfc});
      chk("flip", {6'h00, pfc_tab[i] == 2'h2}, {6'h00, afo});
      chk("debug pin", {6'h00, ps_tab[i] != 3'h3}, {6'h00, dso});
    end
    chk("debug", 7'h00, {6'h00, dso});
    chk("role oe", 7'h00, {6'h00, aroe});
    $display("test orientation done");
    asr <= `TCPD_ROLE_SINK;
    ps <= 3'h1;
    fsrc <= 1'b1;
    cyc(1);
    fsrc <= 1'b0;
    cyc(1);
    chk("forced role", `TCPD_ROLE_SOURCE, {5'h00, acr});
    wait_irq(`TCPD_IRQ_FFAIL, 400);
    chk("role restored", `TCPD_ROLE_SINK, {5'h00, acr});
    chk("pin masked", 7'h00, {6'h00, iaoe});
    fsnk <= 1'b1;
    cyc(1);
    fsnk <= 1'b0;
    wait_irq(`TCPD_IRQ_FDONE, 40);
    mclr <= 1'b1;
    cyc(1);
    mclr <= 1'b0;
    cyc(3);
    chk("pin pending", 7'h01, {6'h00, iaoe});
    clr <= 5'h03;
    cyc(1);
    clr <= 5'h00;
    cyc(3);
    chk("cleared", 7'h00, {5'h00, ist[1:0]});
    chk("pin released", 7'h00, {6'h00, iaoe});
    $display("test force done");
    en_n_pin <= 1'b1;
    rs <= `TCPD_STRAP_HIGH;
    as <= `TCPD_STRAP_FLOAT;
    asr <= `TCPD_ROLE_SOURCE;
    cyc(6);
    en_n_pin <= 1'b0;
    ps <= 3'h3;
    cyc(10);
    chk("pin only", 7'h00, {6'h00, hm});
    chk("debug", 7'h01, {6'h00, dbg});
    chk("role oe", 7'h01, {6'h00, aroe});
    ps <= 3'h4;
    cyc(8);
    chk("audio pin", 7'h01, {6'h00, iaoe});
    chk("audio level", 7'h00, {6'h00, iao});
    chk("role level", 7'h00, {6'h00, aro});
    $display("test pin mode done");
    as <= `TCPD_STRAP_HIGH;
    cyc(4);
    srst <= 1'b1;
    cyc(1);
    srst <= 1'b0;
    cfgv <= 1'b1;
    cfgr <= `TCPD_ROLE_SINK;
    ps <= 3'h1;
    cyc(8);
    chk("host", 7'h01, {6'h00, hm});
    chk("cfg sink", `TCPD_ROLE_SINK, {5'h00, acr});
    chk("role oe", 7'h00, {6'h00, aroe});
    cfgr <= `TCPD_ROLE_DRP;
    cyc(6);
    chk("drp role", `TCPD_ROLE_SOURCE, {5'h00, acr});
    chk("role oe", 7'h01, {6'h00, aroe});
    aud <= 1'b1;
    ps <= 3'h4;
    cyc(8);
    chk("audio report", 7'h01, {6'h00, arep});
    chk("audio irq", 7'h01, {6'h00, ist[`TCPD_IRQ_AUDIO]});
    chk("irq pin", 7'h01, {6'h00, iaoe});
    mset <= 1'b1;
    aud <= 1'b0;
    cyc(1);
    mset <= 1'b0;
    cyc(4);
    chk("irq remasked", 7'h00, {6'h00, iaoe});
    chk("audio off", 7'h00, {6'h00, arep});
    clr <= 5'h1F;
    cyc(1);
    clr <= 5'h00;
    $display("test host config done");
    cfgr <= `TCPD_ROLE_SOURCE;
    lbth <= 4'h9;
    lbe <= 1'b1;
    ps <= 3'h5;
    cyc(8);
    chk("low batt role", `TCPD_ROLE_SINK, {5'h00, acr});
    chk("low batt irq", 7'h01, {6'h00, ist[`TCPD_IRQ_LBATT]});
    ps <= 3'h6;
    cyc(6);
    chk("sink detach", 7'h01, {6'h00, sd});
    lbth <= 4'h8;
    cyc(3);
    chk("threshold", 7'h00, {6'h00, sd});
    lbe <= 1'b0;
    $display("test low battery done");
    lfe <= 1'b1;
    loop_burst();
    wait_irq(`TCPD_IRQ_LOOP, 40);
    clr <= 5'h04;
    lfe <= 1'b0;
    cfe <= 1'b1;
    cyc(1);
    clr <= 5'h00;
    cyc(2);
    chk("loop cleared", 7'h00, {6'h00, ist[`TCPD_IRQ_LOOP]});
    loop_burst();
    wait_irq(`TCPD_IRQ_LOOP, 40);
    $display("test loop fix done");
    summarize();
  end
  // Bounded run length.
  initial begin
    cyc(20000);
    n_fail++;
    summarize();
  end
endmodule
